/* File: fuid_extra_area_model.sv */
// Reference model of the flash extra area that holds the device ID words.
`default_nettype none

module fuid_extra_area_model
	import fuid_pkg::*;
#(
	// The ID word value is arbitrary and stands for a factory code.
	parameter logic [31:0] ID_WORD = 32'h5A3C_96E1
) (
	input wire logic [15:0] addr_i,
	output logic [31:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Word lookup
	// ----------------------------------------------------------------
	// Outside the ID range the model gives zero, so a stray address step shows.
	always_comb begin
		if (addr_i >= ID_BASE && addr_i <= ID_LAST) begin
			data_o = ID_WORD;
		end else begin
			data_o = 32'h0000_0000;
		end
	end
endmodule

`default_nettype wire

/* File: fuid_id_rom.sv */
// Shared constants of the unique ID read sequencer and its ID word store.
`default_nettype none

package fuid_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int APB_AW = 8;
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_RBH = 8'h08;
	localparam logic [7:0] OFS_RBL = 8'h0C;
	localparam logic [7:0] OFS_SAH = 8'h10;
	localparam logic [7:0] OFS_SAL = 8'h14;
	localparam logic [7:0] OFS_EAH = 8'h18;
	localparam logic [7:0] OFS_EAL = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	// ----------------------------------------------------------------
	// Command register fields and codes
	// ----------------------------------------------------------------
	localparam int CMD_MSB = 3;
	localparam int DRC_BIT = 4;
	localparam logic [3:0] CMD_PROGRAM = 4'h1;
	localparam logic [3:0] CMD_BLANK_CHECK = 4'h3;
	localparam logic [3:0] CMD_BLOCK_ERASE = 4'h4;
	localparam logic [3:0] CMD_UNIQUE_ID = 4'h5;
	localparam logic [7:0] CMD_CLEAR = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Status and interrupt bits
	// ----------------------------------------------------------------
	localparam int ST_SEQUENCER_READY_FLAG = 0;
	localparam int ST_READ_DATA_READY_FLAG = 1;
	localparam int ST_ERR = 2;
	localparam int EV_W = 3;
	localparam int EV_DATA = 0;
	localparam int EV_END = 1;
	localparam int EV_ERR = 2;
	// ----------------------------------------------------------------
	// Extra area holding the device ID words
	// ----------------------------------------------------------------
	localparam logic [15:0] ID_BASE = 16'h0850;
	localparam logic [15:0] ID_LAST = 16'h086F;
	localparam logic [15:0] ADDR_STEP = 16'h0004;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam int ID_WORDS = 8;
	localparam int ID_IW = 3;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_LOAD,
		ST_HOLD,
		ST_WAIT
	} fuid_state_t;
endpackage

// --------------------------------------------------------------------
// Device ID word store
// --------------------------------------------------------------------
// Read data is registered, so a word appears one cycle after rd_en_i.
// The default content is arbitrary and stands for a factory ID.
module fuid_id_rom
	import fuid_pkg::*;
#(
	parameter int WORDS = ID_WORDS,
	parameter logic [WORDS*32-1:0] ID_INIT = {WORDS{32'h5A3C_96E1}}
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic rd_en_i,
	input wire logic [$clog2(WORDS)-1:0] idx_i,
	output logic [31:0] data_o
);
	logic [31:0] data_q;
	logic [31:0] data_d;

	always_comb begin
		data_d = data_q;
		if (rd_en_i) begin
			data_d = ID_INIT[idx_i*32 +: 32];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			data_q <= 32'h0000_0000;
		end else begin
			data_q <= data_d;
		end
	end

	assign data_o = data_q;
endmodule

`default_nettype wire

/* File: fuid_seq.sv */
// Unique ID read sequencer with its APB register file and interrupt.
`default_nettype none

module fuid_seq
	import fuid_pkg::*;
#(
	parameter int WORDS = ID_WORDS
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [APB_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o
);
	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	function automatic logic is_mapped(input logic [APB_AW-1:0] a);
		case (a)
			OFS_CMD, OFS_STAT, OFS_RBH, OFS_RBL, OFS_SAH, OFS_SAL,
			OFS_EAH, OFS_EAL, OFS_IRQ_STAT, OFS_IRQ_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic in_id_area(input logic [15:0] hi, input logic [15:0] lo);
		in_id_area = (hi == ADDR_RESET) && (lo >= ID_BASE) && (lo <= ID_LAST);
	endfunction

	logic wr_acc;
	logic setup;
	logic cmd_wr;
	logic [3:0] cmd_code;
	logic read_completion_bit;
	logic cmd_legal;

	assign wr_acc = psel_i && penable_i && pwrite_i && is_mapped(paddr_i);
	assign setup = psel_i && !penable_i;
	assign cmd_wr = wr_acc && (paddr_i == OFS_CMD);
	assign cmd_code = pwdata_i[CMD_MSB:0];
	assign read_completion_bit = pwdata_i[DRC_BIT];
	// Zero-wait slave: every access completes in its first access cycle.
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);

	always_comb begin
		case (cmd_code)
			CMD_PROGRAM, CMD_BLANK_CHECK, CMD_BLOCK_ERASE, CMD_UNIQUE_ID: cmd_legal = 1'b1;
			default: cmd_legal = (pwdata_i[7:0] == CMD_CLEAR);
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	fuid_state_t state_q, state_d;
	logic [15:0] addr_q, addr_d;
	logic [15:0] rbh_q, rbh_d;
	logic [15:0] rbl_q, rbl_d;
	logic drdy_q, drdy_d;
	logic err_q, err_d;
	logic [15:0] sah_q, sal_q, eah_q, eal_q;
	logic rom_rd;
	logic [31:0] rom_data;
	logic area_ok_q, area_ok_d;
	logic sequencer_ready_flag;
	logic uid_wr;
	logic past_end;
	logic [EV_W-1:0] ev;

	// Fetches and loads are busy time; commands written then are ignored.
	assign sequencer_ready_flag = (state_q != ST_FETCH) && (state_q != ST_LOAD);
	assign uid_wr = cmd_wr && sequencer_ready_flag && (cmd_code == CMD_UNIQUE_ID);
	assign past_end = (addr_q + ADDR_STEP) > eal_q;
	assign rom_rd = (state_q == ST_FETCH);

	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		rbh_d = rbh_q;
		rbl_d = rbl_q;
		drdy_d = drdy_q;
		err_d = err_q;
		area_ok_d = area_ok_q;
		ev = '0;
		if (cmd_wr && sequencer_ready_flag) begin
			err_d = !cmd_legal;
			ev[EV_ERR] = !cmd_legal;
		end
		case (state_q)
			ST_IDLE: begin
				if (uid_wr && !read_completion_bit) begin
					addr_d = sal_q;
					area_ok_d = in_id_area(sah_q, sal_q);
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				state_d = ST_LOAD;
			end
			ST_LOAD: begin
				// A word outside the extra area reads as zero.
				rbh_d = area_ok_q ? rom_data[31:16] : 16'h0000;
				rbl_d = area_ok_q ? rom_data[15:0] : 16'h0000;
				drdy_d = 1'b1;
				ev[EV_DATA] = 1'b1;
				state_d = ST_HOLD;
			end
			ST_HOLD, ST_WAIT: begin
				if (uid_wr && read_completion_bit) begin
					drdy_d = 1'b0;
					state_d = ST_WAIT;
				end else if (uid_wr && !read_completion_bit) begin
					drdy_d = 1'b0;
					if (past_end || eah_q != sah_q) begin
						state_d = ST_IDLE;
						ev[EV_END] = 1'b1;
					end else begin
						addr_d = addr_q + ADDR_STEP;
						area_ok_d = in_id_area(sah_q, addr_q + ADDR_STEP);
						state_d = ST_FETCH;
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
			addr_q <= ADDR_RESET;
			rbh_q <= 16'h0000;
			rbl_q <= 16'h0000;
			drdy_q <= 1'b0;
			err_q <= 1'b0;
			area_ok_q <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			rbh_q <= rbh_d;
			rbl_q <= rbl_d;
			drdy_q <= drdy_d;
			err_q <= err_d;
			area_ok_q <= area_ok_d;
		end
	end

	// The ID store is read-only: no write path reaches it.
	fuid_id_rom #(
		.WORDS(WORDS)
	) u_rom (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.rd_en_i(rom_rd),
		.idx_i(ID_IW'((addr_q - ID_BASE) >> 2)),
		.data_o(rom_data)
	);

	// ----------------------------------------------------------------
	// Register file and interrupt
	// ----------------------------------------------------------------
	logic [7:0] fcr_q, fcr_d;
	logic [15:0] sah_d, sal_d, eah_d, eal_d;
	logic [EV_W-1:0] ist_q, ist_d, imask_q, imask_d;
	logic [31:0] rd_q, rd_d;

	always_comb begin
		fcr_d = fcr_q;
		sah_d = sah_q;
		sal_d = sal_q;
		eah_d = eah_q;
		eal_d = eal_q;
		imask_d = imask_q;
		ist_d = ist_q;
		rd_d = rd_q;
		if (wr_acc) begin
			case (paddr_i)
				OFS_CMD: fcr_d = (sequencer_ready_flag) ? pwdata_i[7:0] : fcr_q;
				OFS_SAH: sah_d = pwdata_i[15:0];
				OFS_SAL: sal_d = pwdata_i[15:0];
				OFS_EAH: eah_d = pwdata_i[15:0];
				OFS_EAL: eal_d = pwdata_i[15:0];
				OFS_IRQ_STAT: ist_d = ist_q & ~pwdata_i[EV_W-1:0];
				OFS_IRQ_MASK: imask_d = pwdata_i[EV_W-1:0];
				default: ;
			endcase
		end
		// A new event wins over a clearing write in the same cycle.
		ist_d = ist_d | ev;
		if (setup) begin
			case (paddr_i)
				OFS_CMD: rd_d = {24'h00_0000, fcr_q};
				OFS_STAT: rd_d = {29'h0000_0000, err_q, drdy_q, sequencer_ready_flag};
				OFS_RBH: rd_d = {16'h0000, rbh_q};
				OFS_RBL: rd_d = {16'h0000, rbl_q};
				OFS_SAH: rd_d = {16'h0000, sah_q};
				OFS_SAL: rd_d = {16'h0000, sal_q};
				OFS_EAH: rd_d = {16'h0000, eah_q};
				OFS_EAL: rd_d = {16'h0000, eal_q};
				OFS_IRQ_STAT: rd_d = {29'h0000_0000, ist_q};
				OFS_IRQ_MASK: rd_d = {29'h0000_0000, imask_q};
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			fcr_q <= CMD_RESET;
			sah_q <= ADDR_RESET;
			sal_q <= ADDR_RESET;
			eah_q <= ADDR_RESET;
			eal_q <= ADDR_RESET;
			ist_q <= '0;
			imask_q <= '0;
			rd_q <= 32'h0000_0000;
		end else begin
			fcr_q <= fcr_d;
			sah_q <= sah_d;
			sal_q <= sal_d;
			eah_q <= eah_d;
			eal_q <= eal_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			rd_q <= rd_d;
		end
	end

	assign prdata_o = rd_q;
	assign irq_o = |(ist_q & imask_q);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	a_bad_cmd_flag: assert property (
		(cmd_wr && sequencer_ready_flag && !cmd_legal) |=> (err_q && ist_q[EV_ERR]))
		else $error("prohibited command not flagged");
	a_clear_cmd_ok: assert property (
		(cmd_wr && sequencer_ready_flag && pwdata_i[7:0] == CMD_CLEAR) |=> !err_q)
		else $error("writing 00h flagged as error");
	a_start_fetch: assert property (
		(state_q == ST_IDLE && uid_wr && !read_completion_bit) |=> (state_q == ST_FETCH && addr_q == $past(sal_q))
		##2 drdy_q)
		else $error("start read did not fetch start word");
	a_complete_wait: assert property (
		(state_q == ST_HOLD && uid_wr && read_completion_bit) |=> (state_q == ST_WAIT && !drdy_q && sequencer_ready_flag))
		else $error("completion did not enter wait");
	a_addr_step: assert property (
		(state_q == ST_WAIT && uid_wr && !read_completion_bit && !past_end && eah_q == sah_q)
		|=> addr_q == $past(addr_q) + ADDR_STEP)
		else $error("read address did not step by four");
	a_upper_half: assert property (
		(state_q == ST_LOAD && area_ok_q) |=> rbh_q == $past(rom_data[31:16]))
		else $error("upper buffer mismatch");
	a_lower_half: assert property (
		(state_q == ST_LOAD && area_ok_q) |=> rbl_q == $past(rom_data[15:0]))
		else $error("lower buffer mismatch");
	a_data_ready: assert property (
		$rose(drdy_q) |-> ($past(state_q) == ST_LOAD && state_q == ST_HOLD))
		else $error("data ready rose without a load");
	a_end_reached: assert property (
		(state_q == ST_WAIT && uid_wr && !read_completion_bit && past_end) |=> (!drdy_q && sequencer_ready_flag)[*3])
		else $error("end address handling wrong");
	a_buf_stable: assert property (
		(drdy_q && $past(drdy_q)) |-> ($stable(rbh_q) && $stable(rbl_q)))
		else $error("buffers changed while data ready");

	c_first_word: cover property ((state_q == ST_IDLE && uid_wr && !read_completion_bit) ##3 drdy_q);
	c_next_word: cover property ((state_q == ST_WAIT && uid_wr && !read_completion_bit) ##3 drdy_q);
	c_end_done: cover property (state_q == ST_WAIT && uid_wr && !read_completion_bit && past_end);
	c_irq: cover property ($rose(irq_o));
endmodule

`default_nettype wire

/* File: fuid_seq_tb.sv */
// Self-checking testbench of the unique ID read sequencer.
`default_nettype none

module fuid_seq_tb
	import fuid_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [15:0] model_addr = 16'h0000;
	logic [31:0] model_data;
	logic [31:0] rnd = 32'h0000_b86d;
	logic [31:0] rv;
	logic last_err;
	logic [31:0] exp_q[$];
	int fails = 0;
	int check_count = 0;
	int cycles = 0;

	fuid_seq fuid_seq_i (
		.clk_sys_i(clk_sys),
		.sys_rst_i(sys_rst),
		.psel_i(psel),
		.penable_i(penable),
		.pwrite_i(pwrite),
		.paddr_i(paddr),
		.pwdata_i(pwdata),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.irq_o(irq)
	);
	fuid_extra_area_model fuid_extra_area_model_i (
		.addr_i(model_addr),
		.data_o(model_data)
	);

	always #25 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// A hung handshake is cut short here rather than in every wait loop.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			give_verdict();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_check(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(name, rv, exp);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd_check("status", OFS_STAT, 32'h0000_0001);
		rd_check("irq_status", OFS_IRQ_STAT, 32'h0000_0000);
		check("irq", {31'h0, irq}, 32'h0000_0000);
		$display("test reset done");
		apb(1'b1, OFS_SAH, 32'h0000_0000);
		apb(1'b1, OFS_SAL, 32'h0000_0850);
		apb(1'b1, OFS_EAH, 32'h0000_0000);
		apb(1'b1, OFS_EAL, 32'h0000_086F);
		rd_check("start_lower", OFS_SAL, 32'h0000_0850);
		for (int w = 0; w < ID_WORDS + 1; w++) begin
			model_addr <= ID_BASE + 16'(4 * w);
			@(posedge clk_sys);
			@(posedge clk_sys);
			exp_q.push_back(model_data);
		end
		// Every word must come out with the address stepping by four.
		for (int w = 0; w < ID_WORDS; w++) begin
			apb(1'b1, OFS_CMD, {28'h000_0000, CMD_UNIQUE_ID});
			for (int n = 0; n < 10; n++) begin
				apb(1'b0, OFS_STAT, 32'h0000_0000);
				if (rv[ST_READ_DATA_READY_FLAG] === 1'b1) break;
			end
			check("status_loaded", rv, 32'h0000_0003);
			rd_check("upper_buffer", OFS_RBH, {16'h0, exp_q[w][31:16]});
			rd_check("lower_buffer", OFS_RBL, {16'h0, exp_q[w][15:0]});
			rd_check("upper_again", OFS_RBH, {16'h0, exp_q[w][31:16]});
			apb(1'b1, OFS_CMD, {27'h0, 1'b1, CMD_UNIQUE_ID});
			repeat (2) @(posedge clk_sys);
			rd_check("status_done", OFS_STAT, 32'h0000_0001);
		end
		$display("test id read done");
		apb(1'b1, OFS_CMD, {28'h000_0000, CMD_UNIQUE_ID});
		repeat (4) @(posedge clk_sys);
		rd_check("status_end", OFS_STAT, 32'h0000_0001);
		rd_check("irq_status_end", OFS_IRQ_STAT, 32'h0000_0003);
		$display("test end of range done");
		check("irq_masked", {31'h0, irq}, 32'h0000_0000);
		apb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		check("irq_unmasked", {31'h0, irq}, 32'h0000_0001);
		apb(1'b1, OFS_IRQ_STAT, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		check("irq_cleared", {31'h0, irq}, 32'h0000_0000);
		rd_check("irq_status_w1c", OFS_IRQ_STAT, 32'h0000_0001);
		$display("test interrupt done");
		apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
		for (int c = 0; c < 16; c++) begin
			if (c == 5) continue;
			apb(1'b1, OFS_CMD, 32'(c));
			repeat (3) @(posedge clk_sys);
			rd_check("status_code", OFS_STAT, {29'h0, !(c inside {0, 1, 3, 4}), 2'b01});
		end
		check("irq_bad_code", {31'h0, irq}, 32'h0000_0001);
		apb(1'b1, OFS_IRQ_STAT, 32'h0000_0004);
		repeat (2) @(posedge clk_sys);
		check("irq_bad_cleared", {31'h0, irq}, 32'h0000_0000);
		$display("test command codes done");
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			apb(1'b1, {2'b11, rnd[5:2], 2'b00}, rnd);
			check("unmapped_wr_err", {31'h0, last_err}, 32'h0000_0001);
			rd_check("unmapped_rd", {2'b11, rnd[5:2], 2'b00}, 32'h0000_0000);
			check("unmapped_rd_err", {31'h0, last_err}, 32'h0000_0001);
		end
		rd_check("start_lower_kept", OFS_SAL, 32'h0000_0850);
		$display("test unmapped done");
		// A start just past the ID area must load zero, then end without a completion step.
		apb(1'b1, OFS_SAL, {16'h0000, ID_BASE + 16'(4 * ID_WORDS)});
		apb(1'b1, OFS_CMD, {28'h000_0000, CMD_UNIQUE_ID});
		repeat (4) @(posedge clk_sys);
		rd_check("status_outside", OFS_STAT, 32'h0000_0003);
		rd_check("upper_outside", OFS_RBH, {16'h0000, exp_q[ID_WORDS][31:16]});
		rd_check("lower_outside", OFS_RBL, {16'h0000, exp_q[ID_WORDS][15:0]});
		apb(1'b1, OFS_CMD, {28'h000_0000, CMD_UNIQUE_ID});
		repeat (4) @(posedge clk_sys);
		rd_check("status_outside_end", OFS_STAT, 32'h0000_0001);
		$display("test outside area done");
		give_verdict();
	end
endmodule

`default_nettype wire
